/* File: rtl/mtcc_capture.sv */
`timescale 1ns/1ps
`include "mtcc_defines.svh"
// One capture channel: synchroniser, edge detect, latch
module mtcc_capture
  import mtcc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_sync_n,
  // Pin and control
  input wire logic pin,
  input wire mtcc_edge_t edge_sel,
  input wire logic [CNT_W-1:0] count,
  // Results
  output logic pin_level,
  output logic [CNT_W-1:0] cap_value,
  output logic cap_event
);
  // Elaboration guard: a one-bit counter cannot time anything
  if (CNT_W < 2) begin : g_bad_width
    $error("mtcc_capture: counter too narrow");
  end

  logic sync1, sync2, prev;
  logic next_prev;
  logic [CNT_W-1:0] next_cap_value;
  logic hit;

  // Edge detect works only on the second synchroniser stage
  always_comb begin
    next_prev = sync2;
    hit = 1'b0;
    unique case (edge_sel)
      MTCC_EDGE_OFF: hit = 1'b0;
      MTCC_EDGE_RISE: hit = sync2 & ~prev;
      MTCC_EDGE_FALL: hit = ~sync2 & prev;
      MTCC_EDGE_ANY: hit = sync2 ^ prev;
    endcase
    next_cap_value = hit ? count : cap_value;
  end

  // Synchroniser and capture latch
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
      cap_value <= '0;
      cap_event <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      prev <= next_prev;
      cap_value <= next_cap_value;
      cap_event <= hit;
    end
  end

  assign pin_level = sync2;

  a_cap_latches: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    hit |=> cap_value == $past(count) && cap_event)
    else $error("capture did not latch the counter");
  a_cap_holds: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    !hit |=> cap_value == $past(cap_value))
    else $error("capture register changed without an edge");
  a_cap_rise_only: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (edge_sel == MTCC_EDGE_RISE && $changed(pin_level))
      |=> cap_event == $past(pin_level))
    else $error("rising capture on wrong edge");
endmodule : mtcc_capture

/* File: rtl/mtcc_defines.svh */
`ifndef MTCC_DEFINES_SVH
`define MTCC_DEFINES_SVH

// Counter width and reset
`define MTCC_CNT_W 16
`define MTCC_CNT_RESET 16'h0000
`define MTCC_CNT_MAX 16'hFFFF
// Prescaler factors are selected as 1, 4, 8 or 16 bus clocks per tick
`define MTCC_PRE_W 4
// Watchdog tap: bus clock divided by two to the fifteenth
`define MTCC_WDOG_TAP 15
// Periodic interrupt taps, chain bits 13..16
`define MTCC_RTI_TAP_BASE 13
`define MTCC_CHAIN_W 17
// Channel counts
`define MTCC_N_CAP 3
`define MTCC_N_CMP 5
// Compare action field encodings
`define MTCC_ACT_NONE 2'h0
`define MTCC_ACT_TOGGLE 2'h1
`define MTCC_ACT_CLEAR 2'h2
`define MTCC_ACT_SET 2'h3

`endif

/* File: rtl/mtcc_pkg.sv */
package mtcc_pkg;
  // Capture edge selection
  typedef enum logic [1:0] {
    MTCC_EDGE_OFF,
    MTCC_EDGE_RISE,
    MTCC_EDGE_FALL,
    MTCC_EDGE_ANY
  } mtcc_edge_t;
endpackage : mtcc_pkg

/* File: rtl/mtcc_timer.sv */
`timescale 1ns/1ps
`include "mtcc_defines.svh"
module mtcc_timer
  import mtcc_pkg::*;
#(
  parameter int CNT_W = `MTCC_CNT_W,
  parameter int N_CAP = `MTCC_N_CAP,
  parameter int N_CMP = `MTCC_N_CMP
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Prescaler and periodic rate selection
  input wire logic [1:0] prescale_sel,
  input wire logic [1:0] periodic_rate_sel,
  // Capture configuration
  input wire mtcc_edge_t [N_CAP-1:0] cap_edge_sel,
  // Compare configuration
  input wire logic [N_CMP-1:0][CNT_W-1:0] cmp_value,
  input wire logic [N_CMP-1:0][1:0] cmp_action,
  input wire logic [4:0] master_pin_mask,
  input wire logic [4:0] master_pin_data,
  // Interrupt enables: captures, compares, overflow, periodic
  input wire logic [N_CAP-1:0] cap_irq_en,
  input wire logic [N_CMP-1:0] cmp_irq_en,
  input wire logic ovf_irq_en,
  input wire logic periodic_irq_en,
  // Flag clears, one-cycle pulses, one bit per flag
  input wire logic [N_CAP-1:0] cap_flag_clr,
  input wire logic [N_CMP-1:0] cmp_flag_clr,
  input wire logic ovf_flag_clr,
  input wire logic periodic_flag_clr,
  // Counter read port
  input wire logic cnt_hi_read,
  output logic [7:0] cnt_hi_byte,
  output logic [7:0] cnt_lo_byte,
  // Port pins: three capture inputs
  input wire logic capture_pin_a,
  input wire logic capture_pin_b,
  input wire logic capture_pin_c,
  // Port pins: compare outputs, general outputs
  input wire logic [3:0] gp_out_data,
  output logic [3:0] compare_pins_group,
  // Top pin: output enable low while driving
  input wire logic top_pin_in,
  input wire logic top_pin_gp_dir,
  input wire logic top_pin_gp_data,
  output logic top_port_pin,
  output logic top_pin_oe_n,
  output logic accum_in,
  // Status
  output logic [7:0] timer_port_data_reg,
  output logic [N_CAP-1:0][CNT_W-1:0] cap_value,
  output logic [N_CAP-1:0] cap_flag,
  output logic [N_CMP-1:0] cmp_flag,
  output logic ovf_flag,
  output logic periodic_flag,
  output logic watchdog_supervisor_clk,
  // Separate requests
  output logic [N_CAP-1:0] cap_irq,
  output logic [N_CMP-1:0] cmp_irq,
  output logic ovf_irq,
  output logic periodic_irq
);
  // Elaboration guard: byte ports and pin map assume these sizes
  if (CNT_W != 16) begin : g_bad_width
    $error("mtcc_timer: counter must be 16 bits");
  end
  if (N_CAP != 3 || N_CMP != 5) begin : g_bad_count
    $error("mtcc_timer: fixed channel counts");
  end

  // ==========================================================
  // Reset synchroniser
  logic rst_s1, rst_sync_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_sync_n <= rst_s1;
    end
  end

  // ==========================================================
  // Prescaler, counter and chain taps
  logic [`MTCC_PRE_W-1:0] pre, next_pre;
  logic [CNT_W-1:0] count, next_count;
  logic [`MTCC_CHAIN_W-1:0] chain, next_chain;
  logic tick, wrap;
  logic [7:0] lo_buf, next_lo_buf;
  logic lo_frozen, next_lo_frozen;
  logic periodic_tap, periodic_prev, periodic_edge;

  // Chain runs on raw bus clock so taps ignore the prescaler choice
  always_comb begin
    next_pre = pre + 4'h1;
    unique case (prescale_sel)
      2'h0: tick = 1'b1;
      2'h1: tick = (pre[1:0] == 2'h3);
      2'h2: tick = (pre[2:0] == 3'h7);
      2'h3: tick = (pre == 4'hF);
    endcase
    wrap = tick && (count == `MTCC_CNT_MAX);
    next_count = tick ? count + 16'h0001 : count;
    next_chain = chain + 17'h00001;
    periodic_tap = chain[`MTCC_RTI_TAP_BASE + periodic_rate_sel];
    periodic_edge = periodic_tap & ~periodic_prev;
    // Low byte buffer is transparent unless just frozen by a high read
    next_lo_frozen = cnt_hi_read;
    next_lo_buf = (cnt_hi_read || !lo_frozen) ? count[7:0] : lo_buf;
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pre <= '0;
      count <= `MTCC_CNT_RESET;
      chain <= '0;
      periodic_prev <= 1'b0;
      lo_buf <= 8'h00;
      lo_frozen <= 1'b0;
    end else begin
      pre <= next_pre;
      count <= next_count;
      chain <= next_chain;
      periodic_prev <= periodic_tap;
      lo_buf <= next_lo_buf;
      lo_frozen <= next_lo_frozen;
    end
  end

  assign cnt_hi_byte = count[15:8];
  assign cnt_lo_byte = lo_frozen ? lo_buf : count[7:0];
  assign watchdog_supervisor_clk = chain[`MTCC_WDOG_TAP - 1];

  // ==========================================================
  // Capture channels, all fed the one counter
  logic [N_CAP-1:0] cap_pins, cap_lvl, cap_ev;
  assign cap_pins = {capture_pin_c, capture_pin_b, capture_pin_a};

  for (genvar i = 0; i < N_CAP; i++) begin : g_cap
    mtcc_capture #(.CNT_W(CNT_W)) u_cap (
      .core_clk(core_clk),
      .rst_sync_n(rst_sync_n),
      .pin(cap_pins[i]),
      .edge_sel(cap_edge_sel[i]),
      .count(count),
      .pin_level(cap_lvl[i]),
      .cap_value(cap_value[i]),
      .cap_event(cap_ev[i])
    );
  end

  // ==========================================================
  // Compare match, flags and pin actions
  logic [N_CMP-1:0] match;
  logic [N_CMP-1:0] next_cmp_flag;
  logic [N_CAP-1:0] next_cap_flag;
  logic next_ovf_flag, next_periodic_flag;
  logic [4:0] pins, next_pins;

  // Set wins over a clear in the same cycle
  always_comb begin
    next_pins = pins;
    for (int k = 0; k < N_CMP; k++) begin
      match[k] = (count == cmp_value[k]) && tick;
    end
    // Channels two to five act on their own pin first
    for (int k = 1; k < N_CMP; k++) begin
      if (match[k]) begin
        unique case (cmp_action[k])
          `MTCC_ACT_NONE: next_pins[k-1] = pins[k-1];
          `MTCC_ACT_TOGGLE: next_pins[k-1] = ~pins[k-1];
          `MTCC_ACT_CLEAR: next_pins[k-1] = 1'b0;
          `MTCC_ACT_SET: next_pins[k-1] = 1'b1;
        endcase
      end
    end
    // Master compare overrides any masked pin; it takes priority
    if (match[0]) begin
      for (int k = 0; k < 5; k++) begin
        if (master_pin_mask[k]) next_pins[k] = master_pin_data[k];
      end
    end
    next_cmp_flag = (cmp_flag & ~cmp_flag_clr) | match;
    next_cap_flag = (cap_flag & ~cap_flag_clr) | cap_ev;
    next_ovf_flag = (ovf_flag & ~ovf_flag_clr) | wrap;
    next_periodic_flag = (periodic_flag & ~periodic_flag_clr) | periodic_edge;
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pins <= 5'h00;
      cmp_flag <= '0;
      cap_flag <= '0;
      ovf_flag <= 1'b0;
      periodic_flag <= 1'b0;
    end else begin
      pins <= next_pins;
      cmp_flag <= next_cmp_flag;
      cap_flag <= next_cap_flag;
      ovf_flag <= next_ovf_flag;
      periodic_flag <= next_periodic_flag;
    end
  end

  // ==========================================================
  // Pin muxing; ownership blocks general-purpose writes
  logic [3:0] owned;
  for (genvar p = 0; p < 4; p++) begin : g_pin
    assign owned[p] = (cmp_action[p+1] != `MTCC_ACT_NONE) || master_pin_mask[p];
    assign compare_pins_group[p] = owned[p] ? pins[p] : gp_out_data[p];
  end

  logic top_owned;
  assign top_owned = master_pin_mask[4];
  assign top_port_pin = top_owned ? pins[4] : top_pin_gp_data;
  assign top_pin_oe_n = ~(top_owned | top_pin_gp_dir);
  assign accum_in = top_pin_in;

  assign timer_port_data_reg = {top_pin_oe_n ? top_pin_in : top_port_pin,
                                compare_pins_group, cap_lvl};

  // Separate request per function
  assign cap_irq = cap_flag & cap_irq_en;
  assign cmp_irq = cmp_flag & cmp_irq_en;
  assign ovf_irq = ovf_flag & ovf_irq_en;
  assign periodic_irq = periodic_flag & periodic_irq_en;

  // ==========================================================
  // Checks
  sequence s_wrap;
    tick && count == 16'hFFFF;
  endsequence
  a_cnt_wraps: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    s_wrap |=> count == 16'h0000 && ovf_flag)
    else $error("counter did not wrap with overflow");
  a_cnt_steps: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    tick |=> count == $past(count) + 16'h0001)
    else $error("counter did not advance on tick");
  a_ovf_sticky: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    ovf_flag && !ovf_flag_clr |=> ovf_flag)
    else $error("overflow flag lost");
  a_cmp_match: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    match[1] && cmp_action[1] == 2'h3 && !(match[0] && master_pin_mask[0])
      |=> cmp_flag[1] && pins[0])
    else $error("compare match did not set flag and pin");
  a_lo_freeze: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    cnt_hi_read |=> cnt_lo_byte == $past(count[7:0]))
    else $error("low byte not frozen after high read");
  a_wdog_tap: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    $rose(watchdog_supervisor_clk) |-> watchdog_supervisor_clk [*8])
    else $error("watchdog tap too fast");
  a_irq_gate: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    ovf_irq == (ovf_flag && ovf_irq_en))
    else $error("overflow request not gated");
  a_gp_blocked: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    owned[2] && !match[3] && !(match[0] && master_pin_mask[2])
      |=> !owned[2] || $stable(compare_pins_group[2]))
    else $error("owned pin followed general write");
endmodule : mtcc_timer

/* File: testbench/mtcc_pin_partner.sv */
`timescale 1ns/1ps
// =====================================================
// Pin-side model: capture sources and the top pin wire
module mtcc_pin_partner (
  // Clock and commands from the bench
  input wire logic core_clk,
  input wire logic [2:0] level_req,
  input wire logic slow,
  // Top pin as driven by the timer
  input wire logic top_port_pin,
  input wire logic top_pin_oe_n,
  // Pin levels seen by the timer
  output logic [2:0] cap_pins,
  output logic top_pin_in
);
  // Edges land off the clock; slow mode lands late so sync skew is exercised
  always @(posedge core_clk) begin
    cap_pins <= #(slow ? 17 : 4) level_req;
  end
  // Pull-up holds the top pin high when the timer lets it go
  assign top_pin_in = top_pin_oe_n ? 1'b1 : top_port_pin;
endmodule : mtcc_pin_partner

/* File: testbench/test_main_timer_capture_compare.sv */
`timescale 1ns/1ps
module test_main_timer_capture_compare import mtcc_pkg::*;;
  logic core_clk, rst_n, ovf_irq_en, periodic_irq_en, ovf_flag_clr, periodic_flag_clr;
  logic cnt_hi_read, top_pin_gp_dir, top_pin_gp_data, slow, top_port_pin, top_pin_oe_n;
  logic accum_in, ovf_flag, periodic_flag, watchdog_supervisor_clk, ovf_irq, periodic_irq;
  logic top_pin_in;
  logic [1:0] prescale_sel, periodic_rate_sel;
  mtcc_edge_t [2:0] cap_edge_sel;
  logic [4:0][15:0] cmp_value;
  logic [4:0][1:0] cmp_action;
  logic [4:0] master_pin_mask, master_pin_data, cmp_irq_en, cmp_flag_clr, cmp_flag, cmp_irq;
  logic [2:0] cap_irq_en, cap_flag_clr, level_req, cap_pins, cap_flag, cap_irq;
  logic [7:0] cnt_hi_byte, cnt_lo_byte, timer_port_data_reg, hi, lo;
  logic [3:0] gp_out_data, compare_pins_group;
  logic [2:0][15:0] cap_value;
  logic [15:0] v, w;
  int fail_count, compares, cycles, wd_gap, wd_last;
  logic wd_prev;

  mtcc_timer mtcc_timer_inst (.core_clk(core_clk), .rst_n(rst_n), .prescale_sel(prescale_sel),
    .periodic_rate_sel(periodic_rate_sel), .cap_edge_sel(cap_edge_sel), .cmp_value(cmp_value),
    .cmp_action(cmp_action), .master_pin_mask(master_pin_mask),
    .master_pin_data(master_pin_data), .cap_irq_en(cap_irq_en), .cmp_irq_en(cmp_irq_en),
    .ovf_irq_en(ovf_irq_en), .periodic_irq_en(periodic_irq_en), .cap_flag_clr(cap_flag_clr),
    .cmp_flag_clr(cmp_flag_clr), .ovf_flag_clr(ovf_flag_clr),
    .periodic_flag_clr(periodic_flag_clr), .cnt_hi_read(cnt_hi_read),
    .cnt_hi_byte(cnt_hi_byte), .cnt_lo_byte(cnt_lo_byte), .capture_pin_a(cap_pins[0]),
    .capture_pin_b(cap_pins[1]), .capture_pin_c(cap_pins[2]), .gp_out_data(gp_out_data),
    .compare_pins_group(compare_pins_group), .top_pin_in(top_pin_in),
    .top_pin_gp_dir(top_pin_gp_dir), .top_pin_gp_data(top_pin_gp_data),
    .top_port_pin(top_port_pin), .top_pin_oe_n(top_pin_oe_n), .accum_in(accum_in),
    .timer_port_data_reg(timer_port_data_reg), .cap_value(cap_value), .cap_flag(cap_flag),
    .cmp_flag(cmp_flag), .ovf_flag(ovf_flag), .periodic_flag(periodic_flag),
    .watchdog_supervisor_clk(watchdog_supervisor_clk), .cap_irq(cap_irq), .cmp_irq(cmp_irq),
    .ovf_irq(ovf_irq), .periodic_irq(periodic_irq));
  mtcc_pin_partner mtcc_pin_partner_inst (.core_clk(core_clk), .level_req(level_req),
    .slow(slow), .top_port_pin(top_port_pin), .top_pin_oe_n(top_pin_oe_n),
    .cap_pins(cap_pins), .top_pin_in(top_pin_in));

  // =====================================================
  // Clock, timeout and watchdog period monitor
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (watchdog_supervisor_clk !== wd_prev) begin
      wd_last = wd_gap + 1;
      wd_gap = 0;
    end else wd_gap++;
    wd_prev = watchdog_supervisor_clk;
    if (cycles == 90000) begin
      fail_count++;
      final_report();
    end
  end

  // =====================================================
  // Access and compare tasks; all drives land 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic rd(output logic [15:0] c);
    c = {cnt_hi_byte, cnt_lo_byte};
  endtask : rd
  task automatic chk_eq(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_eq
  task automatic chk_in(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi,
                        input string what);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h outside %h..%h", $time, what, got, lo, hi);
    end
  endtask : chk_in
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // =====================================================
  // Main sequence
  initial begin
    {rst_n, prescale_sel, periodic_rate_sel, cmp_value, cmp_action} = '0;
    {master_pin_mask, master_pin_data, cmp_irq_en, cmp_flag_clr, gp_out_data} = '0;
    {cap_irq_en, cap_flag_clr, level_req, ovf_flag_clr, periodic_flag_clr, slow} = '0;
    {cnt_hi_read, top_pin_gp_dir, top_pin_gp_data, periodic_irq_en} = '0;
    cap_edge_sel = {3{MTCC_EDGE_OFF}};
    ovf_irq_en = 1'b1;
    cyc(6);
    rst_n = 1'b1;
    cyc(4);
    // Counter advances one per clock at the fastest prescale
    rd(v);
    cyc(100);
    rd(w);
    chk_eq(w - v, 16'h0064, "count step");
    // High-byte read freezes the low byte for one cycle
    cnt_hi_read = 1'b1;
    hi = cnt_hi_byte;
    cyc(1);
    cnt_hi_read = 1'b0;
    lo = cnt_lo_byte;
    cyc(1);
    rd(v);
    chk_eq({hi, lo}, v - 16'h0002, "frozen read");
    // Top pin as general output, then released to the pull-up
    top_pin_gp_dir = 1'b1;
    cyc(2);
    chk_eq(top_pin_in, 1'b0, "gp top pin");
    chk_eq(accum_in, top_pin_in, "accum input");
    top_pin_gp_dir = 1'b0;
    // All compare registers equal the count of zero at release, so flags start set
    cmp_flag_clr = 5'h1F;
    cyc(1);
    cmp_flag_clr = 5'h00;
    // Each single-pin compare runs set, clear, toggle against a gp value of 0
    cmp_irq_en = 5'h1F;
    for (int k = 1; k < 5; k++) begin
      for (int a = 0; a < 3; a++) begin
        cmp_action[k] = (a == 0) ? 2'h3 : (a == 1) ? 2'h2 : 2'h1;
        rd(v);
        cmp_value[k] = v + 16'h0010;
        cyc(8);
        chk_eq(cmp_flag[k], 1'b0, "early flag");
        cyc(12);
        chk_eq(cmp_flag[k], 1'b1, "cmp flag");
        chk_eq(cmp_irq[k], 1'b1, "cmp request");
        chk_eq(compare_pins_group[k-1], (a != 1), "cmp pin");
        cmp_flag_clr[k] = 1'b1;
        cyc(1);
        cmp_flag_clr[k] = 1'b0;
        cyc(1);
      end
    end
    // Master compare drives all five pins including the top pin
    master_pin_mask = 5'h1F;
    master_pin_data = 5'h05;
    rd(v);
    cmp_value[0] = v + 16'h0010;
    cyc(20);
    chk_eq(cmp_flag[0], 1'b1, "master flag");
    chk_eq(compare_pins_group, 4'h5, "master pins");
    chk_eq({top_pin_oe_n, top_pin_in}, 2'h0, "master top");
    // Capture every edge code on every pin, alternating pin level
    cap_irq_en = 3'h7;
    for (int c = 0; c < 3; c++) begin
      slow = (c == 2);
      for (int e = 0; e < 4; e++) begin
        cap_edge_sel[c] = (e == 0) ? MTCC_EDGE_RISE : (e == 1) ? MTCC_EDGE_FALL :
                          (e == 2) ? MTCC_EDGE_ANY : MTCC_EDGE_OFF;
        cyc(1);
        rd(v);
        level_req[c] = ~level_req[c];
        cyc(8);
        chk_eq(cap_flag[c], (e != 3), "cap flag");
        chk_eq(cap_irq[c], (e != 3), "cap request");
        chk_eq(timer_port_data_reg[c], level_req[c], "pin level");
        if (e != 3) chk_in(cap_value[c] - v, 16'h0001, 16'h0006, "cap time");
        cap_flag_clr[c] = 1'b1;
        cyc(1);
        cap_flag_clr[c] = 1'b0;
      end
    end
    // Run to the wrap; periodic and watchdog taps tick meanwhile
    // Slowest periodic rate first rises with the wrap, so its flag trails by one cycle
    periodic_rate_sel = 2'h3;
    periodic_flag_clr = 1'b1;
    cyc(1);
    periodic_flag_clr = 1'b0;
    chk_eq(ovf_flag, 1'b0, "no early wrap");
    for (int i = 0; i < 70000 && ovf_flag !== 1'b1; i++) cyc(1);
    rd(v);
    chk_in(v, 16'h0000, 16'h0003, "wrap to zero");
    chk_eq(ovf_irq, 1'b1, "ovf request");
    chk_eq({periodic_flag, periodic_irq}, 2'h0, "periodic not yet");
    chk_eq(16'(wd_last), 16'h4000, "watchdog half period");
    ovf_flag_clr = 1'b1;
    cyc(1);
    ovf_flag_clr = 1'b0;
    chk_eq({periodic_flag, periodic_irq}, 2'h2, "periodic masked");
    cyc(1);
    chk_eq(ovf_flag, 1'b0, "ovf cleared");
    // Prescale factors 1, 4, 8, 16 over 160 clocks
    for (int s = 0; s < 4; s++) begin
      prescale_sel = 2'(s);
      cyc(20);
      rd(v);
      cyc(160);
      rd(w);
      chk_in(w - v, 16'(160 / (1 << (s == 0 ? 0 : s + 1)) - 1),
             16'(160 / (1 << (s == 0 ? 0 : s + 1)) + 1), "prescale");
    end
    final_report();
  end
endmodule : test_main_timer_capture_compare
